// ### inc/gor_defines.vh
// Constants for the gating override and restart interlock controller.
// Assumes a single 40 MHz device clock; times are kept in milliseconds.
`ifndef GOR_DEFINES_VH
`define GOR_DEFINES_VH

// ----------------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------------
`define GOR_CLK_KHZ        33'd40000

// ----------------------------------------------------------------------
// Times in ms, as printed or chosen
// ----------------------------------------------------------------------
`define GOR_PRESS_MIN_MS   33'd150
`define GOR_PRESS_MAX_MS   33'd4000
`define GOR_OVR_MAX_MS     33'd120000
`define GOR_OVR_LOCK_MS    33'd150000
`define GOR_DEBOUNCE_MS    33'd10
`define GOR_BLINK_HALF_MS  33'd250

`endif

// ### hw/gor_debounce.v
// Button conditioner: two-stage synchroniser and stability debouncer.
// Assumes a raw pin input from outside the clock domain.
`timescale 1ns/1ps
`include "gor_defines.vh"

module gor_debounce #(
    parameter [32:0] DEB_CYC = `GOR_DEBOUNCE_MS * `GOR_CLK_KHZ
) (
    input  wire mclk_i,
    input  wire reset_i,
    input  wire raw_i,
    output reg  level_o
);

    reg        sync1_q;
    reg        sync2_q;
    reg [32:0] stable_cnt_q;

    // ------------------------------------------------------------------
    // Synchroniser and stability counter
    // ------------------------------------------------------------------
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q      <= 1'b0;
            sync2_q      <= 1'b0;
            stable_cnt_q <= 33'h0;
            level_o      <= 1'b0;
        end else begin
            sync1_q <= raw_i;
            sync2_q <= sync1_q;
            // Contact bounce must settle for a full window first
            if (sync2_q == level_o) begin
                stable_cnt_q <= 33'h0;
            end else if (stable_cnt_q >= DEB_CYC - 33'h1) begin
                stable_cnt_q <= 33'h0;
                level_o      <= sync2_q;
            end else begin
                stable_cnt_q <= stable_cnt_q + 33'h1;
            end
        end
    end

endmodule // gor_debounce

// ### hw/gor_ctrl.v
// Override sequence and start/restart interlock of a light curtain
// receiver. Assumes all inputs are pins from outside the clock domain.
//
// How it works
// (R01) Override starts with press-release lasting 0.15 s to 4 s.
// (R02) A second press, held, switches the safety outputs on.
// (R03) Valid gating at release keeps outputs on, normal operation resumes.
// (R04) Invalid gating: outputs stay on only while button stays pressed.
// (R05) Override outputs drop on release or after 120 s.
// (R06) Button still held at 150 s puts the device into interlock.
// (R07) After that interlock a fresh press-and-hold continues the override.
// (R08) Gating start plus interrupted field after second press continues gating.
// (R09) Indicator toggles low/high while that gating continues.
// (R10) Operator clears any error before trying override.
// (R11) Outputs stay off after field clears following an interruption.
// (R12) Outputs stay off after power returns; no automatic release.
// (R13) Override only with field, both sync beams blocked, gating start.
// (R14) Accepted press in locked-off state releases interlock, turns on.
// (R15) Press durations timed by clocked counter after debouncing.
`timescale 1ns/1ps
`include "gor_defines.vh"

module gor_ctrl #(
    parameter [32:0] PRESS_MIN_CYC = `GOR_PRESS_MIN_MS * `GOR_CLK_KHZ,
    parameter [32:0] PRESS_MAX_CYC = `GOR_PRESS_MAX_MS * `GOR_CLK_KHZ,
    parameter [32:0] OVR_MAX_CYC   = `GOR_OVR_MAX_MS * `GOR_CLK_KHZ,
    parameter [32:0] OVR_LOCK_CYC  = `GOR_OVR_LOCK_MS * `GOR_CLK_KHZ,
    parameter [32:0] DEB_CYC       = `GOR_DEBOUNCE_MS * `GOR_CLK_KHZ,
    parameter [32:0] BLINK_CYC     = `GOR_BLINK_HALF_MS * `GOR_CLK_KHZ
) (
    input  wire mclk_i,
    input  wire reset_i,
    input  wire reset_button_i,
    input  wire field_clear_i,
    input  wire sync_beams_blocked_i,
    input  wire gating_start_i,
    input  wire gating_valid_i,
    input  wire error_present_i,
    output reg  safety_switch_outputs_o,
    output reg  gating_indicator_output_o,
    output reg  restart_interlock_o,
    output reg  override_active_o
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [5:0] ST_LOCKED   = 6'h01;
    localparam [5:0] ST_ON       = 6'h02;
    localparam [5:0] ST_OVR_ARM  = 6'h04;
    localparam [5:0] ST_OVR_ON   = 6'h08;
    localparam [5:0] ST_OVR_TOUT = 6'h10;
    localparam [5:0] ST_OVR_LOCK = 6'h20;

    reg  [5:0]  state_q;
    reg  [5:0]  state_d;
    reg  [4:0]  sync1_q;
    reg  [4:0]  sync2_q;
    reg         btn_prev_q;
    reg  [32:0] press_cnt_q;
    reg  [32:0] ovr_cnt_q;
    reg  [32:0] blink_cnt_q;
    reg         blink_q;
    wire        btn;
    wire        field_clear;
    wire        beams_blk;
    wire        gate_start;
    wire        gate_valid;
    wire        err;
    wire        released;
    wire        press_ok;
    wire        ovr_cond;
    wire        gate_cont;
    wire        blinking;
    wire        in_ovr;

    function press_in_window;
        input [32:0] cnt;
        begin
            press_in_window = (cnt >= PRESS_MIN_CYC) &&
                              (cnt <= PRESS_MAX_CYC);
        end
    endfunction

    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    gor_debounce #(
        .DEB_CYC (DEB_CYC)
    ) gor_debounce_inst (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .raw_i   (reset_button_i),
        .level_o (btn)
    ); // [R15]

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {error_present_i, gating_valid_i, gating_start_i,
                        sync_beams_blocked_i, field_clear_i};
            sync2_q <= sync1_q;
        end
    end

    assign field_clear = sync2_q[0];
    assign beams_blk   = sync2_q[1];
    assign gate_start  = sync2_q[2];
    assign gate_valid  = sync2_q[3];
    assign err         = sync2_q[4];

    assign released  = btn_prev_q & ~btn;
    assign press_ok  = released & press_in_window(press_cnt_q); // [R01]
    // Error blocks entry; clearing it is up to the operator [R10]
    assign ovr_cond  = ~field_clear & beams_blk & gate_start & ~err; // [R13]
    assign gate_cont = gate_start & ~field_clear; // [R08]
    assign in_ovr    = (state_q == ST_OVR_ON) || (state_q == ST_OVR_TOUT);
    assign blinking  = (state_q == ST_OVR_ON) & gate_cont; // [R09]

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            btn_prev_q  <= 1'b0;
            press_cnt_q <= 33'h0;
            ovr_cnt_q   <= 33'h0;
            blink_cnt_q <= 33'h0;
            blink_q     <= 1'b0;
        end else begin
            btn_prev_q <= btn;
            // Saturate so a very long hold never wraps into the window
            if (!btn) begin
                press_cnt_q <= 33'h0;
            end else if (press_cnt_q <= PRESS_MAX_CYC) begin
                press_cnt_q <= press_cnt_q + 33'h1; // [R15]
            end
            if (!in_ovr) begin
                ovr_cnt_q <= 33'h0;
            end else if (ovr_cnt_q < OVR_LOCK_CYC) begin
                ovr_cnt_q <= ovr_cnt_q + 33'h1;
            end
            if (!blinking) begin
                blink_cnt_q <= 33'h0;
                blink_q     <= 1'b0;
            end else if (blink_cnt_q >= BLINK_CYC - 33'h1) begin
                blink_cnt_q <= 33'h0;
                blink_q     <= ~blink_q; // [R09]
            end else begin
                blink_cnt_q <= blink_cnt_q + 33'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_LOCKED: begin
                if (press_ok && ovr_cond) begin
                    state_d = ST_OVR_ARM; // [R01]
                end else if (press_ok && field_clear && !err) begin
                    state_d = ST_ON; // [R14]
                end
            end
            ST_ON: begin
                if (err || (!field_clear && !gate_valid)) begin
                    state_d = ST_LOCKED; // [R11]
                end
            end
            ST_OVR_ARM: begin
                if (!ovr_cond) begin
                    state_d = ST_LOCKED;
                end else if (btn && !btn_prev_q) begin
                    state_d = ST_OVR_ON; // [R02]
                end
            end
            ST_OVR_ON: begin
                if (err) begin
                    state_d = ST_LOCKED;
                end else if (!btn) begin
                    // Valid gating carries on without the button
                    if (gate_valid && gate_start) begin
                        state_d = ST_ON; // [R03]
                    end else begin
                        state_d = ST_LOCKED; // [R04] [R05]
                    end
                end else if (ovr_cnt_q >= OVR_MAX_CYC) begin
                    state_d = ST_OVR_TOUT; // [R05]
                end
            end
            ST_OVR_TOUT: begin
                if (!btn) begin
                    state_d = ST_LOCKED;
                end else if (ovr_cnt_q >= OVR_LOCK_CYC) begin
                    state_d = ST_OVR_LOCK; // [R06]
                end
            end
            ST_OVR_LOCK: begin
                // Step-by-step: release, then press-and-hold again
                if (!btn) begin
                    state_d = ST_OVR_ARM; // [R07]
                end
            end
            default: begin
                state_d = ST_LOCKED;
            end
        endcase
    end

    // Power-up always lands in locked-off; nothing releases by itself
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q                   <= ST_LOCKED; // [R12]
            safety_switch_outputs_o   <= 1'b0;
            gating_indicator_output_o <= 1'b0;
            restart_interlock_o       <= 1'b1;
            override_active_o         <= 1'b0;
        end else begin
            state_q                   <= state_d;
            safety_switch_outputs_o   <= (state_d == ST_ON) ||
                                         (state_d == ST_OVR_ON); // [R04]
            gating_indicator_output_o <= blinking ? blink_q
                                                  : ~field_clear;
            restart_interlock_o       <= (state_d == ST_LOCKED); // [R11]
            override_active_o         <= (state_d == ST_OVR_ARM) ||
                                         (state_d == ST_OVR_ON) ||
                                         (state_d == ST_OVR_TOUT) ||
                                         (state_d == ST_OVR_LOCK);
        end
    end

endmodule // gor_ctrl

// ### tb/gor_ctrl_checker.sv
// Port-level checks for the override and restart interlock controller.
// Assumes small bench parameter values and one clock domain.
`timescale 1ns/1ps
module gor_ctrl_checker #(
    parameter [32:0] OVR_MAX_CYC = 33'd50,
    parameter [32:0] BLINK_CYC   = 33'd4
) (
    input wire mclk_i,
    input wire reset_i,
    input wire reset_button_i,
    input wire field_clear_i,
    input wire sync_beams_blocked_i,
    input wire gating_start_i,
    input wire gating_valid_i,
    input wire error_present_i,
    input wire safety_switch_outputs_o,
    input wire gating_indicator_output_o,
    input wire restart_interlock_o,
    input wire override_active_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    reg  [32:0] on_q;
    reg  [32:0] still_q;
    reg         ind_q;
    wire        ovr_on = override_active_o && safety_switch_outputs_o;
    wire        blink  = ovr_on && gating_start_i && !field_clear_i;
    // Run lengths, so long limits need no long repetitions
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            on_q    <= 33'h0;
            still_q <= 33'h0;
            ind_q   <= 1'b0;
        end else begin
            on_q    <= ovr_on ? on_q + 33'h1 : 33'h0;
            ind_q   <= gating_indicator_output_o;
            still_q <= (blink && gating_indicator_output_o == ind_q) ?
                       still_q + 33'h1 : 33'h0;
        end
    end
    AST_RESET_LOCKED: assert property ($fell(reset_i) |->
        restart_interlock_o && !safety_switch_outputs_o)
        else $error("outputs not locked off after reset");
    AST_LOCK_OFF: assert property (restart_interlock_o |->
        !safety_switch_outputs_o) else $error("outputs on while locked");
    AST_OVR_COND: assert property ($rose(override_active_o) |->
        $past(sync_beams_blocked_i, 4) && $past(gating_start_i, 4) &&
        !$past(field_clear_i, 4)) else $error("override without cause");
    AST_RELEASE_DROP: assert property ($fell(reset_button_i) &&
        ovr_on |-> ##[1:12] !ovr_on) else $error("override kept on");
    AST_OVR_LIMIT: assert property (on_q <= OVR_MAX_CYC + 33'd2)
        else $error("override longer than limit");
    AST_BLINK: assert property (still_q <= BLINK_CYC)
        else $error("indicator not toggling");
    AST_ERR_OFF: assert property ($rose(error_present_i) |->
        ##[1:6] !safety_switch_outputs_o) else $error("error kept on");
    AST_LOCK_EXIT: assert property ($fell(restart_interlock_o) |->
        safety_switch_outputs_o || override_active_o)
        else $error("interlock left with nothing on");
endmodule // gor_ctrl_checker

// ### tb/gor_operator.sv
// Operator model: presses the button for a set count, or holds it.
// Assumes requests only while idle; button high means pressed.
`timescale 1ns/1ps
module gor_operator (
    input  wire       mclk_i,
    input  wire       go_i,
    input  wire [7:0] len_i,
    input  wire       hold_i,
    output wire       button_o
);
    reg [7:0] cnt_q = 8'h0;
    // Timed press and release, the first override step
    always @(posedge mclk_i) begin
        if (go_i && cnt_q == 8'h0) begin
            cnt_q <= len_i;
        end else if (cnt_q != 8'h0) begin
            cnt_q <= cnt_q - 8'h1;
        end
    end
    assign button_o = (cnt_q != 8'h0) || hold_i;
endmodule // gor_operator

// ### tb/gor_ctrl_tb.sv
// Self-checking bench for the override and restart interlock controller.
// Assumes shortened timing parameters; no error pending at the start.
`timescale 1ns/1ps
module gor_ctrl_tb;
    logic mclk_i = 0, reset_i = 1, go = 0, hold = 0, fc = 1, bb = 0;
    logic gs = 0, gv = 0, er = 0;
    logic [7:0] len = 8'h0;
    wire  btn, sso, gio, rio, oao;
    int   error_cnt = 0, tests_run = 0, cyc = 0;
    always #12.5 mclk_i = ~mclk_i;
    // Shortened timing so every limit is reached within the run
    localparam [32:0] P_MIN  = 33'd6;
    localparam [32:0] P_MAX  = 33'd20;
    localparam [32:0] O_MAX  = 33'd50;
    localparam [32:0] O_LOCK = 33'd70;
    localparam [32:0] DEB    = 33'd3;
    localparam [32:0] BLINK  = 33'd4;
    gor_ctrl #(.PRESS_MIN_CYC(P_MIN), .PRESS_MAX_CYC(P_MAX),
        .OVR_MAX_CYC(O_MAX), .OVR_LOCK_CYC(O_LOCK), .DEB_CYC(DEB),
        .BLINK_CYC(BLINK)) gor_ctrl_inst (.mclk_i(mclk_i),
        .reset_i(reset_i), .reset_button_i(btn), .field_clear_i(fc),
        .sync_beams_blocked_i(bb), .gating_start_i(gs),
        .gating_valid_i(gv), .error_present_i(er),
        .safety_switch_outputs_o(sso), .gating_indicator_output_o(gio),
        .restart_interlock_o(rio), .override_active_o(oao));
    gor_operator gor_operator_inst (.mclk_i(mclk_i), .go_i(go),
        .len_i(len), .hold_i(hold), .button_o(btn));
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic press(input int n);
        cyc_n(1);
        len = n[7:0];
        go = 1;
        cyc_n(1);
        go = 0;
        cyc_n(n + 20);
    endtask
    task automatic setin(input bit f, b, s, v, e);
        cyc_n(1);
        {fc, bb, gs, gv, er} = {f, b, s, v, e};
        cyc_n(8);
    endtask
    task automatic t_lock;
        chk(rio === 1'b1 && sso === 1'b0, "not locked at start");
        press(4);
        chk(rio === 1'b1, "short press taken");
        press(30);
        chk(rio === 1'b1, "long press taken");
        press(12);
        chk(sso === 1'b1 && rio === 1'b0, "press did not release");
        setin(0, 0, 0, 0, 0);
        setin(1, 0, 0, 0, 0);
        chk(sso === 1'b0 && rio === 1'b1, "auto restart");
    endtask
    task automatic t_err;
        press(12);
        setin(1, 0, 0, 0, 1);
        press(12);
        chk(sso === 1'b0, "on despite error");
        setin(1, 0, 0, 0, 0);
        setin(0, 0, 1, 0, 0);
        press(12);
        chk(oao === 1'b0, "override without beams");
    endtask
    task automatic t_ovr(input bit valid);
        int t, n;
        logic p;
        t = 0;
        n = 0;
        setin(0, 1, 1, 0, 0);
        press(12);
        chk(oao === 1'b1 && sso === 1'b0, "override not armed");
        hold = 1;
        cyc_n(12);
        chk(sso === 1'b1, "hold did not switch on");
        p = gio;
        // Half period of BLINK cycles: about five toggles in twenty
        repeat (20) begin
            n += (gio !== p) ? 1 : 0;
            p = gio;
            t += (gio === 1'b1) ? 1 : 0;
            cyc_n(1);
        end
        chk(t > 5 && t < 15 && n > 3 && n < 7, "no blink");
        gv = valid;
        cyc_n(4);
        hold = 0;
        cyc_n(15);
        chk(sso === valid && oao === 1'b0, "release outcome");
        setin(0, 0, 0, 0, 0);
    endtask
    task automatic t_tout;
        setin(0, 1, 1, 0, 0);
        press(12);
        hold = 1;
        cyc_n(40);
        chk(sso === 1'b1, "override ended early");
        cyc_n(25);
        chk(sso === 1'b0, "override past limit");
        cyc_n(25);
        hold = 0;
        cyc_n(15);
        chk(oao === 1'b1, "no step after lock");
        hold = 1;
        cyc_n(12);
        chk(sso === 1'b1, "step did not continue");
        hold = 0;
        cyc_n(15);
        chk(sso === 1'b0, "step kept on");
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            $display("BAD %0t run too long", $time);
            stop_test();
        end
    end
    initial begin
        cyc_n(12);
        reset_i = 0;
        cyc_n(10);
        t_lock();
        t_err();
        t_ovr(1'b1);
        t_ovr(1'b0);
        t_tout();
        stop_test();
    end
endmodule // gor_ctrl_tb
bind gor_ctrl gor_ctrl_checker #(.OVR_MAX_CYC(OVR_MAX_CYC),
    .BLINK_CYC(BLINK_CYC)) gor_ctrl_checker_inst (.mclk_i(mclk_i),
    .reset_i(reset_i), .reset_button_i(reset_button_i),
    .field_clear_i(field_clear_i),
    .sync_beams_blocked_i(sync_beams_blocked_i),
    .gating_start_i(gating_start_i), .gating_valid_i(gating_valid_i),
    .error_present_i(error_present_i),
    .safety_switch_outputs_o(safety_switch_outputs_o),
    .gating_indicator_output_o(gating_indicator_output_o),
    .restart_interlock_o(restart_interlock_o),
    .override_active_o(override_active_o));
